/* hdl/irq_instr_map.vh */
`ifndef IRQ_INSTR_MAP_VH
`define IRQ_INSTR_MAP_VH
// ---------------------------------------------------------------------------
// Opcodes and field codes
// ---------------------------------------------------------------------------
`define OP_ACCU_TO_GP 8'h23
`define OP_CLEAR_ERR 8'h24
`define OP_IRQ_EN 8'h19
`define OP_IRQ_DIS 8'h1A
`define OP_DEF_DEFINE_HANDLER_ADDRESS 8'h25
`define OP_RET_HANDLER 8'h26
`define IRQ_GLOBAL 8'hFF
`define CLE_ALL 8'h00
`define CLE_TIMEOUT 8'h01
`define CLE_ALARM 8'h02
`define CLE_DEVIATION 8'h03
`define CLE_POSITION 8'h04
`define CLE_SHUTDOWN 8'h05
`define BANK_0 8'h00
`define BANK_2 8'h02
`define BANK_3 8'h03
// ---------------------------------------------------------------------------
// Avalon register offsets (byte addresses) and bit positions
// ---------------------------------------------------------------------------
`define REG_CMD_LO 6'h00
`define REG_CMD_HI 6'h04
`define REG_CMD_GO 6'h08
`define REG_ACCU 6'h0C
`define REG_XREG 6'h10
`define REG_PC 6'h14
`define REG_STATUS 6'h18
`define REG_MASK 6'h1C
`define REG_ERRFLAGS 6'h20
`define REG_GP_DATA 6'h24
`define REG_STATE 6'h28
`define ST_DONE 0
`define ST_CKSUM 1
`define ST_REJECT 2
`define ST_DISPATCH 3
`define ST_GP_WRITE 4
`define STATUS_W 5
`define FRAME_ADDR 8'h01
`endif

/* hdl/vector_mem.v */
`timescale 1ns/10ps
// ---------------------------------------------------------------------------
// Handler entry table, registered read
// ---------------------------------------------------------------------------
module vector_mem #(
  parameter AW = 8,
  parameter DW = 32
)(
  input wire clk_in,
  input wire we_in,
  input wire [AW-1:0] waddr_in,
  input wire [DW-1:0] wdata_in,
  input wire [AW-1:0] raddr_in,
  output reg [DW-1:0] rdata_out
);
  reg [DW-1:0] mem [0:(1<<AW)-1];
  always @(posedge clk_in)
  begin
    if (we_in)
    begin
      mem[waddr_in] <= wdata_in;
    end
    rdata_out <= mem[raddr_in];
  end
endmodule // vector_mem

/* hdl/irq_instr_unit.v */
`timescale 1ns/10ps
`include "irq_instr_map.vh"
module irq_instr_unit #(
  parameter NIRQ = 16
)(
  input wire clk_in,
  input wire rst_n_in,
  input wire [5:0] avs_address_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire [31:0] avs_writedata_in,
  output reg [31:0] avs_readdata_out,
  output reg avs_waitrequest_out,
  input wire [NIRQ-1:0] irq_src_in,
  input wire [4:0] err_set_in,
  input wire standalone_in,
  input wire [31:0] accu_in,
  input wire [31:0] xreg_in,
  input wire [7:0] flags_in,
  input wire [31:0] pc_in,
  output reg [31:0] accu_out,
  output reg [31:0] xreg_out,
  output reg [7:0] flags_out,
  output reg [31:0] pc_out,
  output reg restore_out,
  output reg jump_out,
  output reg gp_we_out,
  output reg [7:0] gp_index_out,
  output reg [7:0] gp_bank_out,
  output reg [31:0] gp_data_out,
  output reg [4:0] err_flags_out,
  output reg irq_out
);
  // -------------------------------------------------------------------------
  // State
  // -------------------------------------------------------------------------
  localparam S_IDLE = 2'd0;
  localparam S_EXEC = 2'd1;
  localparam S_VREAD = 2'd2;
  localparam S_VJUMP = 2'd3;
  reg [1:0] state_r;
  reg [31:0] cmd_lo_r;
  reg [31:0] cmd_hi_r;
  reg [NIRQ-1:0] src_sync1_r;
  reg [NIRQ-1:0] src_sync2_r;
  reg [NIRQ-1:0] src_prev_r;
  reg [NIRQ-1:0] pend_r;
  reg [NIRQ-1:0] en_r;
  reg glob_en_r;
  reg in_handler_r;
  reg [4:0] err_sync1_r;
  reg [4:0] err_sync2_r;
  reg [`STATUS_W-1:0] status_r;
  reg [`STATUS_W-1:0] mask_r;
  reg [31:0] sv_accu_r;
  reg [31:0] sv_xreg_r;
  reg [7:0] sv_flags_r;
  reg [31:0] sv_pc_r;
  reg [7:0] define_handler_address_sel_r;
  reg [7:0] cur_irq_r;
  // -------------------------------------------------------------------------
  // Frame decode, low word holds bytes 0..3, high word bytes 4..7
  // -------------------------------------------------------------------------
  wire [7:0] f_addr = cmd_lo_r[31:24];
  wire [7:0] f_op = cmd_lo_r[23:16];
  wire [7:0] f_type = cmd_lo_r[15:8];
  wire [7:0] f_bank = cmd_lo_r[7:0];
  wire [31:0] f_value = cmd_hi_r;
  wire [7:0] f_sum = f_addr + f_op + f_type + f_bank + cmd_hi_r[31:24]
    + cmd_hi_r[23:16] + cmd_hi_r[15:8] + cmd_hi_r[7:0];
  wire bus_wr = avs_write_in && avs_waitrequest_out;
  wire bus_rd = avs_read_in && avs_waitrequest_out;
  wire go = bus_wr && avs_address_in == `REG_CMD_GO;
  wire type_ok = f_type < NIRQ;
  wire [NIRQ-1:0] type_bit = type_ok ? ({{(NIRQ-1){1'b0}}, 1'b1} << f_type)
    : {NIRQ{1'b0}};
  wire bank_ok = f_bank == `BANK_0 || f_bank == `BANK_2
    || f_bank == `BANK_3;
  // -------------------------------------------------------------------------
  // Lowest pending enabled source
  // -------------------------------------------------------------------------
  reg [7:0] win_id;
  reg win_hit;
  integer i;
  always @*
  begin
    win_id = 8'h00;
    win_hit = 1'b0;
    for (i = NIRQ - 1; i >= 0; i = i - 1)
    begin
      if (pend_r[i] && en_r[i])
      begin
        win_id = i[7:0];
        win_hit = 1'b1;
      end
    end
  end
  wire [31:0] define_handler_address_rdata;
  wire [NIRQ-1:0] src_rise = src_sync2_r & ~src_prev_r;
  // The ninth frame byte, the checksum, rides in the low byte of the go write.
  reg [7:0] cksum_r;
  wire sum_ok = f_sum == cksum_r;
  wire addr_ok = f_addr == `FRAME_ADDR;
  wire exec_ok = state_r == S_EXEC && sum_ok && addr_ok;
  vector_mem #(
    .AW(8),
    .DW(32)
  ) u_define_handler_address (
    .clk_in(clk_in),
    .we_in(exec_ok && f_op == `OP_DEF_DEFINE_HANDLER_ADDRESS && standalone_in && type_ok),
    .waddr_in(f_type),
    .wdata_in(f_value),
    .raddr_in(define_handler_address_sel_r),
    .rdata_out(define_handler_address_rdata)
  );
  // -------------------------------------------------------------------------
  // Main process
  // -------------------------------------------------------------------------
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_r <= S_IDLE;
      cmd_lo_r <= 32'h0000_0000;
      cmd_hi_r <= 32'h0000_0000;
      cksum_r <= 8'h00;
      src_sync1_r <= {NIRQ{1'b0}};
      src_sync2_r <= {NIRQ{1'b0}};
      src_prev_r <= {NIRQ{1'b0}};
      pend_r <= {NIRQ{1'b0}};
      en_r <= {NIRQ{1'b0}};
      glob_en_r <= 1'b0;
      in_handler_r <= 1'b0;
      err_sync1_r <= 5'h00;
      err_sync2_r <= 5'h00;
      err_flags_out <= 5'h00;
      status_r <= {`STATUS_W{1'b0}};
      mask_r <= {`STATUS_W{1'b0}};
      sv_accu_r <= 32'h0000_0000;
      sv_xreg_r <= 32'h0000_0000;
      sv_flags_r <= 8'h00;
      sv_pc_r <= 32'h0000_0000;
      define_handler_address_sel_r <= 8'h00;
      cur_irq_r <= 8'h00;
      accu_out <= 32'h0000_0000;
      xreg_out <= 32'h0000_0000;
      flags_out <= 8'h00;
      pc_out <= 32'h0000_0000;
      restore_out <= 1'b0;
      jump_out <= 1'b0;
      gp_we_out <= 1'b0;
      gp_index_out <= 8'h00;
      gp_bank_out <= 8'h00;
      gp_data_out <= 32'h0000_0000;
      avs_readdata_out <= 32'h0000_0000;
      avs_waitrequest_out <= 1'b1;
      irq_out <= 1'b0;
    end
    else
    begin
      restore_out <= 1'b0;
      jump_out <= 1'b0;
      gp_we_out <= 1'b0;
      src_sync1_r <= irq_src_in;
      src_sync2_r <= src_sync1_r;
      src_prev_r <= src_sync2_r;
      err_sync1_r <= err_set_in;
      err_sync2_r <= err_sync1_r;
      // One wait cycle per access: answer on the second edge.
      avs_waitrequest_out <= !(avs_read_in || avs_write_in)
        || !avs_waitrequest_out;
      if (bus_wr)
      begin
        case (avs_address_in)
          `REG_CMD_LO: cmd_lo_r <= avs_writedata_in;
          `REG_CMD_HI: cmd_hi_r <= avs_writedata_in;
          `REG_CMD_GO: cksum_r <= avs_writedata_in[7:0];
          `REG_MASK: mask_r <= avs_writedata_in[`STATUS_W-1:0];
          default: ;
        endcase
      end
      if (bus_rd)
      begin
        case (avs_address_in)
          `REG_CMD_LO: avs_readdata_out <= cmd_lo_r;
          `REG_CMD_HI: avs_readdata_out <= cmd_hi_r;
          `REG_ACCU: avs_readdata_out <= accu_out;
          `REG_XREG: avs_readdata_out <= xreg_out;
          `REG_PC: avs_readdata_out <= pc_out;
          `REG_STATUS: avs_readdata_out <= {27'h000_0000, status_r};
          `REG_MASK: avs_readdata_out <= {27'h000_0000, mask_r};
          `REG_ERRFLAGS: avs_readdata_out <= {27'h000_0000, err_flags_out};
          `REG_GP_DATA: avs_readdata_out <= gp_data_out;
          `REG_STATE: avs_readdata_out <= {14'h0000, glob_en_r,
            in_handler_r, en_r[NIRQ-1:0] & 16'hFFFF};
          default: avs_readdata_out <= 32'h0000_0000;
        endcase
      end
      pend_r <= pend_r | src_rise;
      // Error inputs set flags; a set in the clearing cycle wins.
      err_flags_out <= err_flags_out | err_sync2_r;
      // Clear first, so that an event in the same cycle still sets its bit.
      if (bus_wr && avs_address_in == `REG_STATUS)
      begin
        status_r <= status_r & ~avs_writedata_in[`STATUS_W-1:0];
      end
      case (state_r)
        S_IDLE:
        begin
          if (go)
          begin
            state_r <= S_EXEC;
          end
          else if (win_hit && glob_en_r && !in_handler_r && standalone_in)
          begin
            define_handler_address_sel_r <= win_id;
            cur_irq_r <= win_id;
            state_r <= S_VREAD;
          end
        end
        S_EXEC:
        begin
          state_r <= S_IDLE;
          status_r[`ST_DONE] <= 1'b1;
          if (!(sum_ok && addr_ok))
          begin
            status_r[`ST_CKSUM] <= 1'b1;
          end
          else
          begin
            case (f_op)
              `OP_ACCU_TO_GP:
              begin
                if (bank_ok)
                begin
                  gp_we_out <= 1'b1;
                  gp_index_out <= f_type;
                  gp_bank_out <= f_bank;
                  gp_data_out <= accu_in;
                  status_r[`ST_GP_WRITE] <= 1'b1;
                end
                else
                  status_r[`ST_REJECT] <= 1'b1;
              end
              `OP_CLEAR_ERR:
              begin
                case (f_type)
                  `CLE_ALL: err_flags_out <= err_sync2_r;
                  `CLE_TIMEOUT: err_flags_out[0] <= err_sync2_r[0];
                  `CLE_ALARM: err_flags_out[1] <= err_sync2_r[1];
                  `CLE_DEVIATION: err_flags_out[2] <= err_sync2_r[2];
                  `CLE_POSITION: err_flags_out[3] <= err_sync2_r[3];
                  `CLE_SHUTDOWN: err_flags_out[4] <= err_sync2_r[4];
                  default: status_r[`ST_REJECT] <= 1'b1;
                endcase
              end
              `OP_IRQ_EN:
              begin
                if (f_type == `IRQ_GLOBAL)
                  glob_en_r <= 1'b1;
                else
                  en_r <= en_r | type_bit;
              end
              `OP_IRQ_DIS:
              begin
                if (f_type == `IRQ_GLOBAL)
                  glob_en_r <= 1'b0;
                else
                  en_r <= en_r & ~type_bit;
              end
              `OP_DEF_DEFINE_HANDLER_ADDRESS:
              begin
                if (!standalone_in || !type_ok)
                  status_r[`ST_REJECT] <= 1'b1;
              end
              `OP_RET_HANDLER:
              begin
                if (standalone_in && in_handler_r)
                begin
                  accu_out <= sv_accu_r;
                  xreg_out <= sv_xreg_r;
                  flags_out <= sv_flags_r;
                  pc_out <= sv_pc_r;
                  restore_out <= 1'b1;
                  in_handler_r <= 1'b0;
                end
                else
                  status_r[`ST_REJECT] <= 1'b1;
              end
              default: status_r[`ST_REJECT] <= 1'b1;
            endcase
          end
        end
        S_VREAD: state_r <= S_VJUMP;
        S_VJUMP:
        begin
          sv_accu_r <= accu_in;
          sv_xreg_r <= xreg_in;
          sv_flags_r <= flags_in;
          sv_pc_r <= pc_in;
          pc_out <= define_handler_address_rdata;
          jump_out <= 1'b1;
          in_handler_r <= 1'b1;
          // A fresh edge in the dispatch cycle keeps its pending bit.
          pend_r[cur_irq_r[3:0]] <= src_rise[cur_irq_r[3:0]];
          status_r[`ST_DISPATCH] <= 1'b1;
          state_r <= S_IDLE;
        end
        default: state_r <= S_IDLE;
      endcase
      irq_out <= |(status_r & mask_r);
    end
  end
endmodule // irq_instr_unit

/* verif/irq_instr_unit_props.sv */
`timescale 1ns/10ps
module irq_instr_unit_props #(
  parameter NIRQ = 16
)(
  input wire clk_in,
  input wire rst_n_in,
  input wire avs_read_in,
  input wire avs_write_in,
  input wire avs_waitrequest_out,
  input wire standalone_in,
  input wire gp_we_out,
  input wire [7:0] gp_bank_out,
  input wire jump_out,
  input wire restore_out,
  input wire [4:0] err_flags_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  sequence taken;
    (avs_read_in || avs_write_in) && avs_waitrequest_out;
  endsequence
  // Three idle write cycles let any clear command finish first.
  sequence quiet;
    !avs_write_in [*3];
  endsequence
  property release_p;
    !avs_waitrequest_out |=> avs_waitrequest_out;
  endproperty
  property bank_p;
    gp_we_out |-> gp_bank_out inside {8'h00, 8'h02, 8'h03};
  endproperty
  // Dispatch is decided three edges before the jump pulse shows.
  property jump_mode_p;
    jump_out |-> $past(standalone_in, 3);
  endproperty
  // Return is decided one edge before the restore pulse shows.
  property ret_mode_p;
    restore_out |-> $past(standalone_in);
  endproperty
  property flags_hold_p;
    quiet |=> (err_flags_out & $past(err_flags_out)) == $past(err_flags_out);
  endproperty
  a_bus_answer: assert property (taken |=> !avs_waitrequest_out)
    else $error("request not answered next cycle");
  a_bus_release: assert property (release_p)
    else $error("waitrequest low too long");
  a_gp_bank: assert property (bank_p)
    else $error("parameter write to illegal bank");
  a_gp_pulse: assert property (gp_we_out |=> !gp_we_out)
    else $error("parameter write not a pulse");
  a_jump_pulse: assert property (jump_out |=> !jump_out)
    else $error("dispatch not a pulse");
  a_jump_mode: assert property (jump_mode_p)
    else $error("dispatch outside program mode");
  a_ret_mode: assert property (ret_mode_p)
    else $error("return honoured outside program mode");
  a_no_overlap: assert property (!(jump_out && restore_out))
    else $error("return and dispatch together");
  a_flags_hold: assert property (flags_hold_p)
    else $error("error flag dropped without command");
endmodule // irq_instr_unit_props
bind irq_instr_unit irq_instr_unit_props #(.NIRQ(NIRQ)) u_props (
  .clk_in(clk_in),
  .rst_n_in(rst_n_in),
  .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in),
  .avs_waitrequest_out(avs_waitrequest_out),
  .standalone_in(standalone_in),
  .gp_we_out(gp_we_out),
  .gp_bank_out(gp_bank_out),
  .jump_out(jump_out),
  .restore_out(restore_out),
  .err_flags_out(err_flags_out)
);

/* verif/host_model.sv */
`timescale 1ns/10ps
`include "irq_instr_map.vh"
module host_model (
  input wire clk_in,
  input wire [31:0] rdata_in,
  input wire wait_in,
  output logic [5:0] addr_out = 6'h0,
  output logic rd_out = 1'b0,
  output logic wr_out = 1'b0,
  output logic [31:0] wdata_out = 32'h0
);
  int tmo = 0;
  // --------
  // Bus master
  // --------
  task automatic xfer(input logic w, input logic [5:0] a,
    input logic [31:0] d, output logic [31:0] q);
    int i;
    @(posedge clk_in);
    addr_out <= a;
    wdata_out <= d;
    wr_out <= w;
    rd_out <= !w;
    i = 0;
    do
    begin
      @(posedge clk_in);
      i++;
    end
    while (wait_in !== 1'b0 && i < 50);
    if (wait_in !== 1'b0)
      tmo++;
    q = rdata_in;
    rd_out <= 1'b0;
    wr_out <= 1'b0;
    // Idle lines must not look like a held request.
    addr_out <= ~a;
    wdata_out <= ~d;
  endtask
  task automatic frame(input logic [7:0] op, ty, bk,
    input logic [31:0] v, input logic bad);
    logic [7:0] s;
    logic [31:0] q;
    s = `FRAME_ADDR + op + ty + bk + v[31:24] + v[23:16] + v[15:8] + v[7:0];
    xfer(1'b1, `REG_CMD_LO, {`FRAME_ADDR, op, ty, bk}, q);
    xfer(1'b1, `REG_CMD_HI, v, q);
    xfer(1'b1, `REG_CMD_GO, {24'h0, s ^ {7'h0, bad}}, q);
  endtask
endmodule // host_model

/* verif/irq_instr_unit_test.sv */
`timescale 1ns/10ps
`include "irq_instr_map.vh"
module irq_instr_unit_test;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [5:0] addr;
  logic rd, wr, waitreq, standalone = 1'b0, restore, jump, gp_we, irq;
  logic [31:0] wdata, rdata, accu_i = 0, xreg_i = 0, pc_i = 0;
  logic [31:0] accu_o, xreg_o, pc_o, gp_data;
  logic [15:0] irq_src = 16'h0;
  logic [4:0] err_set = 5'h0, err_flags;
  logic [7:0] flags_i = 8'h0, flags_o, gp_index, gp_bank;
  wire [2:0] ev = {restore, jump, gp_we};
  int n_errors = 0;
  int check_count = 0;
  irq_instr_unit u_dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wdata), .avs_readdata_out(rdata),
    .avs_waitrequest_out(waitreq), .irq_src_in(irq_src),
    .err_set_in(err_set), .standalone_in(standalone), .accu_in(accu_i),
    .xreg_in(xreg_i), .flags_in(flags_i), .pc_in(pc_i), .accu_out(accu_o),
    .xreg_out(xreg_o), .flags_out(flags_o), .pc_out(pc_o),
    .restore_out(restore), .jump_out(jump), .gp_we_out(gp_we),
    .gp_index_out(gp_index), .gp_bank_out(gp_bank), .gp_data_out(gp_data),
    .err_flags_out(err_flags), .irq_out(irq));
  host_model u_host (.clk_in(clk_in), .rdata_in(rdata), .wait_in(waitreq),
    .addr_out(addr), .rd_out(rd), .wr_out(wr), .wdata_out(wdata));
  initial
    forever #50 clk_in = ~clk_in;
  task automatic chk(input string nm, input logic [31:0] e, g);
    check_count++;
    if (g !== e)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wait_ev(input int k, input logic want);
    int i;
    i = 0;
    while (ev[k] !== 1'b1 && i < 40)
    begin
      @(posedge clk_in);
      i++;
    end
    chk("event", 32'(want), 32'(i < 40));
    if (want && i == 40)
      end_of_test;
  endtask
  task automatic fire(input logic [31:0] pc, input logic want);
    irq_src[3] <= 1'b1;
    wait_ev(1, want);
    if (want)
      chk("pc_out", pc, pc_o);
    irq_src[3] <= 1'b0;
    repeat (4) @(posedge clk_in);
  endtask
  task automatic ret(input logic want);
    accu_i <= 32'h2222_0002;
    pc_i <= 32'h0000_0099;
    u_host.frame(`OP_RET_HANDLER, 8'hFF, 8'h00, 32'h0, 1'b0);
    wait_ev(2, want);
    if (want)
    begin
      chk("accu_out", 32'h1111_0001, accu_o);
      chk("pc_out", 32'h0000_0077, pc_o);
      chk("xreg_out", 32'h3333_0003, xreg_o);
      chk("flags_out", 32'h0000_005A, 32'(flags_o));
    end
    accu_i <= 32'h1111_0001;
    pc_i <= 32'h0000_0077;
  endtask
  task automatic end_of_test;
    n_errors += u_host.tmo;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    #5_000_000;
    n_errors++;
    end_of_test;
  end
  // A bus wait that runs out ends the run at once.
  always @(posedge clk_in)
  begin
    if (u_host.tmo != 0)
      end_of_test;
  end
  // --------
  // Scenarios
  // --------
  initial
  begin
    logic [31:0] q;
    int k;
    repeat (8) @(posedge clk_in);
    rst_n_in <= 1'b1;
    u_host.xfer(1'b0, 6'h3C, 32'h0, q);
    chk("unmapped", 32'h0, q);
    for (k = 0; k < 4; k++)
    begin
      accu_i <= 32'hA5A5_0000 + k;
      u_host.frame(`OP_ACCU_TO_GP, 8'h2A, 8'(k), 32'h1234_5678, 1'b0);
      wait_ev(0, k != 1);
      if (k != 1)
      begin
        chk("gp_sel", {8'h2A, 8'(k)}, {gp_index, gp_bank});
        chk("gp_data", 32'hA5A5_0000 + k, gp_data);
      end
    end
    for (k = 0; k < 7; k++)
    begin
      err_set <= 5'h1F;
      repeat (4) @(posedge clk_in);
      err_set <= 5'h00;
      repeat (4) @(posedge clk_in);
      u_host.frame(`OP_CLEAR_ERR, 8'(k % 6), 8'h07, 32'hFFFF_FFFF, k == 6);
      repeat (4) @(posedge clk_in);
      q = (k == 0) ? 32'h0 : 32'h1F & ~((k < 6) << (k - 1));
      chk("err_flags", q, 32'(err_flags));
    end
    u_host.xfer(1'b0, `REG_STATUS, 32'h0, q);
    chk("cksum_err", 32'h1, 32'(q[`ST_CKSUM]));
    standalone <= 1'b1;
    accu_i <= 32'h1111_0001;
    xreg_i <= 32'h3333_0003;
    flags_i <= 8'h5A;
    pc_i <= 32'h0000_0077;
    u_host.frame(`OP_DEF_DEFINE_HANDLER_ADDRESS, 8'h03, 8'h00, 32'h0000_0032, 1'b0);
    u_host.frame(`OP_IRQ_EN, 8'h03, 8'h00, 32'h0, 1'b0);
    u_host.frame(`OP_IRQ_EN, `IRQ_GLOBAL, 8'h00, 32'h0, 1'b0);
    fire(32'h0000_0032, 1'b1);
    ret(1'b1);
    u_host.frame(`OP_DEF_DEFINE_HANDLER_ADDRESS, 8'h03, 8'h00, 32'h0000_0040, 1'b0);
    fire(32'h0000_0040, 1'b1);
    standalone <= 1'b0;
    ret(1'b0);
    standalone <= 1'b1;
    ret(1'b1);
    u_host.frame(`OP_IRQ_DIS, 8'h03, 8'h00, 32'h0, 1'b0);
    fire(32'h0, 1'b0);
    u_host.frame(`OP_IRQ_DIS, `IRQ_GLOBAL, 8'h00, 32'h0, 1'b0);
    u_host.frame(`OP_IRQ_EN, 8'h03, 8'h00, 32'h0, 1'b0);
    fire(32'h0, 1'b0);
    u_host.xfer(1'b1, `REG_MASK, 32'h0000_001F, q);
    repeat (2) @(posedge clk_in);
    chk("irq_set", 32'h1, 32'(irq));
    u_host.xfer(1'b1, `REG_STATUS, 32'h0000_001F, q);
    u_host.xfer(1'b0, `REG_STATUS, 32'h0, q);
    chk("status", 32'h0, q);
    chk("irq_clr", 32'h0, 32'(irq));
    end_of_test;
  end
endmodule // irq_instr_unit_test
